// ==== common/nisc_params.svh ====
// Purpose: constants of the interrupt pending/active state block
// Assumes: 32-bit AXI4-Lite register window, word aligned
// Notes: offsets are byte addresses
`ifndef NISC_PARAMS_SVH
`define NISC_PARAMS_SVH
`define NISC_NUM_IRQ 30
`define NISC_PRIO_W 3
`define NISC_ID_W 5
`define NISC_OFS_ENABLE 8'h00
`define NISC_OFS_SETPEND 8'h04
`define NISC_OFS_CLRPEND 8'h08
`define NISC_OFS_ACTIVE 8'h0c
`define NISC_OFS_PULSE 8'h10
`define NISC_OFS_SOFTWARE_TRIGGER_REG 8'h14
`define NISC_OFS_GROUP 8'h18
`define NISC_OFS_PRESENT 8'h1c
`define NISC_OFS_EVSTAT 8'h20
`define NISC_OFS_EVCLR 8'h24
`define NISC_OFS_EVEN 8'h28
`define NISC_OFS_PRIO0 8'h40
`define NISC_PRIO_WORDS 4
`define NISC_RST_ZERO 32'h0000_0000
`define NISC_RESP_OKAY 2'b00
`define NISC_RESP_SLVERR 2'b10
`endif

// ==== common/nisc_pkg.sv ====
// Purpose: types of the interrupt pending/active state block
// Assumes: constants come from nisc_params.svh
// Notes: none
`include "nisc_params.svh"
package nisc_pkg;
  typedef logic [`NISC_NUM_IRQ-1:0] nisc_vec_t;
  typedef logic [`NISC_PRIO_W-1:0] nisc_prio_t;
  typedef logic [`NISC_ID_W-1:0] nisc_id_t;
  typedef enum logic [1:0]
  {
    NISC_W_IDLE = 2'b00,
    NISC_W_RESP = 2'b01
  } nisc_wst_t;
  typedef struct packed
  {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } nisc_axi_req_t;
  typedef struct packed
  {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } nisc_axi_rsp_t;
  typedef struct packed
  {
    logic take;
    nisc_id_t take_id;
    logic ret;
    nisc_id_t ret_id;
  } nisc_core_req_t;
  typedef struct packed
  {
    logic irq_valid;
    nisc_id_t irq_id;
    nisc_prio_t irq_group;
    nisc_prio_t irq_sub;
    logic nmi;
  } nisc_core_rsp_t;
endpackage

// ==== src/nisc_ctrl.sv ====
// Purpose: per-interrupt pending and active state with AXI4-Lite registers
// Assumes: request lines synchronous to clk_in
// Notes: one write and one read in flight at a time
`timescale 1ns/10ps
`include "nisc_params.svh"
// Behaviour
// RL1 - thirty inputs, each with priority 0..7, zero most urgent
// RL2 - each input is either level-sensitive or pulse detected
// RL3 - pulses sampled on rising clock edge and latched pending
// RL4 - peripheral holds a pulse high at least one clock
// RL5 - peripheral holds a level request until service no longer needed
// RL6 - entering service clears pending and sets active
// RL7 - line high while not active makes the interrupt pending
// RL8 - a rising edge on the line makes the interrupt pending
// RL9 - set-pending bit or software trigger number makes it pending
// RL10 - level return: line still high means pending, else inactive
// RL11 - pulse during service gives pending and active, pending after return
// RL12 - pulse with no new pulse in service goes inactive on return
// RL13 - clear-pending on level leaves state while line high, else inactive
// RL14 - clear-pending on pulse drops pending, keeps active
// RL15 - priority split into group and subpriority by a grouping setting
// RL16 - an external non-maskable input is provided
// RL17 - present smallest enabled pending priority, ties to lower number
module nisc_ctrl
(
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // peripheral requests and nmi
  input wire nisc_pkg::nisc_vec_t irq_in,
  input wire logic nmi_in,
  // core side
  input wire nisc_pkg::nisc_core_req_t core_in,
  output nisc_pkg::nisc_core_rsp_t core_out,
  // register bus
  input wire nisc_pkg::nisc_axi_req_t axi_in,
  output nisc_pkg::nisc_axi_rsp_t axi_out,
  // event interrupt
  output logic evirq_out
);
  import nisc_pkg::*;

  typedef struct packed
  {
    nisc_vec_t en;
    nisc_vec_t pend;
    nisc_vec_t act;
    nisc_vec_t pulse;
    nisc_vec_t line;
    logic [`NISC_NUM_IRQ*`NISC_PRIO_W-1:0] prio;
    logic [2:0] group;
    logic [1:0] evst;
    logic [1:0] even;
    nisc_axi_rsp_t axi;
    nisc_core_rsp_t core;
    logic evirq;
  } nisc_state_t;

  nisc_state_t s_q;
  nisc_state_t s_d;

  function automatic nisc_prio_t prio_of(input nisc_state_t s,
                                         input int i);
    prio_of = s.prio[i*`NISC_PRIO_W +: `NISC_PRIO_W];
  endfunction

  // group setting g: top (3-g) bits are group priority, rest subpriority
  function automatic nisc_prio_t grp_mask(input logic [2:0] g);
    grp_mask = (g >= 3'h3) ? 3'h0 : nisc_prio_t'(3'h7 << g);
  endfunction

  logic [7:0] waddr;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] rdat;
  logic rd_ok;
  logic wr_ok;
  nisc_vec_t setp;
  nisc_vec_t clrp;
  nisc_vec_t rise;
  nisc_vec_t req;
  nisc_vec_t cand;
  logic found;
  nisc_id_t best_id;
  nisc_prio_t best_p;
  int pidx;

  assign waddr = axi_in.awaddr;
  assign wr_fire = axi_in.awvalid && axi_in.wvalid && !s_q.axi.bvalid;
  assign rd_fire = axi_in.arvalid && !s_q.axi.rvalid;

  always_comb
  begin
    rdat = `NISC_RST_ZERO;
    rd_ok = 1'b1;
    pidx = 0;
    case (axi_in.araddr)
      `NISC_OFS_ENABLE: rdat = 32'(s_q.en);
      `NISC_OFS_SETPEND: rdat = 32'(s_q.pend);
      `NISC_OFS_CLRPEND: rdat = 32'(s_q.pend);
      `NISC_OFS_ACTIVE: rdat = 32'(s_q.act);
      `NISC_OFS_PULSE: rdat = 32'(s_q.pulse);
      `NISC_OFS_GROUP: rdat = 32'(s_q.group);
      `NISC_OFS_PRESENT: rdat = 32'({s_q.core.irq_valid, s_q.core.irq_id});
      `NISC_OFS_EVSTAT: rdat = 32'(s_q.evst);
      `NISC_OFS_EVEN: rdat = 32'(s_q.even);
      default:
      begin
        if (axi_in.araddr >= `NISC_OFS_PRIO0 &&
            axi_in.araddr < `NISC_OFS_PRIO0 + 8'(4 * `NISC_PRIO_WORDS))
        begin
          pidx = 8 * int'(axi_in.araddr[3:2]);
          for (int k = 0; k < 8; k++)
            if (pidx + k < `NISC_NUM_IRQ)
              rdat[k*4 +: 3] = prio_of(s_q, pidx + k); // see RL1
        end
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    wr_ok = (waddr <= `NISC_OFS_EVEN) && (waddr[1:0] == 2'b00) ||
            (waddr >= `NISC_OFS_PRIO0 &&
             waddr < `NISC_OFS_PRIO0 + 8'(4 * `NISC_PRIO_WORDS));
    setp = '0;
    clrp = '0;
    if (wr_fire && waddr == `NISC_OFS_SETPEND)
      setp = axi_in.wdata[`NISC_NUM_IRQ-1:0]; // see RL9
    if (wr_fire && waddr == `NISC_OFS_SOFTWARE_TRIGGER_REG &&
        axi_in.wdata[7:0] < 8'(`NISC_NUM_IRQ))
      setp[axi_in.wdata[`NISC_ID_W-1:0]] = 1'b1; // see RL9
    if (wr_fire && waddr == `NISC_OFS_CLRPEND)
      clrp = axi_in.wdata[`NISC_NUM_IRQ-1:0];
  end

  // rising edge against the previous clock's sample
  assign rise = irq_in & ~s_q.line; // see RL3
  always_comb
  begin
    for (int i = 0; i < `NISC_NUM_IRQ; i++)
      // a level line seen in the entry cycle must not undo the entry
      req[i] = s_q.pulse[i] ? rise[i] : // see RL2
               (irq_in[i] && !s_q.act[i] &&
                !(core_in.take && core_in.take_id == nisc_id_t'(i)));
  end

  // arbitration: lowest priority value wins, lower id on ties
  assign cand = s_q.en & s_q.pend;
  always_comb
  begin
    found = 1'b0;
    best_id = '0;
    best_p = '1;
    for (int i = 0; i < `NISC_NUM_IRQ; i++)
      if (cand[i] && (!found || prio_of(s_q, i) < best_p))
      begin
        found = 1'b1;
        best_id = nisc_id_t'(i);
        best_p = prio_of(s_q, i); // see RL17
      end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.line = irq_in;
    for (int i = 0; i < `NISC_NUM_IRQ; i++)
    begin
      if (clrp[i])
      begin
        if (s_q.pulse[i])
          s_d.pend[i] = 1'b0; // see RL14
        else if (!irq_in[i])
          s_d.pend[i] = 1'b0; // see RL13
      end
      if (core_in.ret && core_in.ret_id == nisc_id_t'(i))
      begin
        s_d.act[i] = 1'b0; // see RL12
        if (!s_q.pulse[i] && irq_in[i])
          s_d.pend[i] = 1'b1; // see RL10
      end
      if (core_in.take && core_in.take_id == nisc_id_t'(i))
      begin
        s_d.pend[i] = 1'b0; // see RL6
        s_d.act[i] = 1'b1;
      end
      // new request wins over clear and entry; pulse in service
      // keeps both pending and active
      if (req[i] || setp[i])
        s_d.pend[i] = 1'b1; // see RL7 see RL8 see RL11
    end
    s_d.core.irq_valid = found;
    s_d.core.irq_id = best_id;
    s_d.core.irq_group = best_p & grp_mask(s_q.group); // see RL15
    s_d.core.irq_sub = best_p & ~grp_mask(s_q.group);
    s_d.core.nmi = nmi_in; // see RL16
    // bus slave
    if (s_q.axi.bvalid && axi_in.bready)
      s_d.axi.bvalid = 1'b0;
    if (s_q.axi.rvalid && axi_in.rready)
      s_d.axi.rvalid = 1'b0;
    s_d.axi.awready = 1'b0;
    s_d.axi.wready = 1'b0;
    s_d.axi.arready = 1'b0;
    if (wr_fire)
    begin
      s_d.axi.awready = 1'b1;
      s_d.axi.wready = 1'b1;
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = wr_ok ? `NISC_RESP_OKAY : `NISC_RESP_SLVERR;
      case (waddr)
        `NISC_OFS_ENABLE: s_d.en = axi_in.wdata[`NISC_NUM_IRQ-1:0];
        `NISC_OFS_PULSE: s_d.pulse = axi_in.wdata[`NISC_NUM_IRQ-1:0];
        `NISC_OFS_GROUP: s_d.group = axi_in.wdata[2:0];
        `NISC_OFS_EVCLR: s_d.evst = s_d.evst & ~(axi_in.wdata[1:0] &
                                    s_q.evst);
        `NISC_OFS_EVEN: s_d.even = axi_in.wdata[1:0];
        default:
        begin
          if (waddr >= `NISC_OFS_PRIO0 &&
              waddr < `NISC_OFS_PRIO0 + 8'(4 * `NISC_PRIO_WORDS))
            for (int k = 0; k < 8; k++)
              if (8 * int'(waddr[3:2]) + k < `NISC_NUM_IRQ &&
                  axi_in.wstrb[k/2])
                s_d.prio[(8*int'(waddr[3:2])+k)*`NISC_PRIO_W +:
                  `NISC_PRIO_W] = axi_in.wdata[k*4 +: 3]; // see RL1
        end
      endcase
    end
    if (rd_fire)
    begin
      s_d.axi.arready = 1'b1;
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = rdat;
      s_d.axi.rresp = rd_ok ? `NISC_RESP_OKAY : `NISC_RESP_SLVERR;
    end
    // events set again in the clearing cycle stay set
    if (found && !s_q.core.irq_valid)
      s_d.evst[0] = 1'b1;
    if (nmi_in && !s_q.core.nmi)
      s_d.evst[1] = 1'b1;
    s_d.evirq = |(s_d.evst & s_d.even);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      s_q <= '0;
    else if (ce_in)
      s_q <= s_d;
  end

  assign core_out = s_q.core;
  assign axi_out = s_q.axi;
  assign evirq_out = s_q.evirq;

  // entry and return of the level input that the checks below watch
  sequence seq_take3;
    ce_in && core_in.take && core_in.take_id == 5'd3 && !core_in.ret;
  endsequence
  sequence seq_ret3;
    ce_in && core_in.ret && core_in.ret_id == 5'd3 && !core_in.take;
  endsequence

  AST_TAKE_ACTIVE: assert property ( // see RL6
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && core_in.take && !core_in.ret && core_in.take_id < 5'd30
    |=> s_q.act[$past(core_in.take_id)])
    else $error("entry did not mark active");
  AST_TAKE_CLEARS: assert property ( // see RL6
    @(posedge clk_in) disable iff (!rstn_in)
    seq_take3 ##0 (!s_q.pulse[3] && !setp[3])
    |=> !s_q.pend[3] && s_q.act[3])
    else $error("entry left level input pending");
  AST_CLR_LEVEL_HELD: assert property ( // see RL13
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && !core_in.take && !core_in.ret && clrp[3] && !s_q.pulse[3]
    && irq_in[3] && s_q.pend[3] |=> s_q.pend[3])
    else $error("held level lost pending on clear");
  AST_PULSE_LATCH: assert property ( // see RL3
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && s_q.pulse[5] && rise[5] |=> s_q.pend[5])
    else $error("pulse not latched");
  AST_LEVEL_PEND: assert property ( // see RL7
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && !s_q.pulse[3] && irq_in[3] && !s_q.act[3] &&
    !(core_in.take && core_in.take_id == 5'd3) |=> s_q.pend[3])
    else $error("level request not pending");
  AST_RET_INACT: assert property ( // see RL12
    @(posedge clk_in) disable iff (!rstn_in)
    seq_ret3 |=> !s_q.act[3])
    else $error("return left active");
  AST_LEVEL_RET: assert property ( // see RL10
    @(posedge clk_in) disable iff (!rstn_in)
    seq_ret3 ##0 (!s_q.pulse[3] && irq_in[3]) |=> s_q.pend[3])
    else $error("held level not pending after return");
  AST_PULSE_CLR: assert property ( // see RL14
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && clrp[5] && s_q.pulse[5] && !rise[5] && !setp[5]
    |=> !s_q.pend[5])
    else $error("pulse clear left pending");
  AST_PRESENT: assert property ( // see RL17
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && found |=> s_q.core.irq_valid && s_q.core.irq_id == $past(best_id))
    else $error("winner not presented");
  AST_NMI: assert property ( // see RL16
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> core_out.nmi == $past(nmi_in))
    else $error("nmi not passed");
  AST_NMI_EVENT: assert property ( // see RL16
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && nmi_in && !s_q.core.nmi |=> s_q.evst[1])
    else $error("nmi event not recorded");
  AST_SOFTWARE_TRIGGER_REG: assert property ( // see RL9
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_fire && waddr == `NISC_OFS_SOFTWARE_TRIGGER_REG &&
    axi_in.wdata[7:0] == 8'h05 |=> s_q.pend[5])
    else $error("software trigger ignored");
endmodule

// ==== tb/nisc_src_model.sv ====
// Purpose: peripheral request sources for the state block
// Assumes: bench commands change just after a rising edge
// Notes: pulses last one clock, the shortest legal width
`timescale 1ns/10ps
module nisc_src_model
(
  // clock
  input wire logic clk_in,
  // commands from the bench
  input wire nisc_pkg::nisc_vec_t hold_in,
  input wire nisc_pkg::nisc_vec_t fire_in,
  // request lines
  output nisc_pkg::nisc_vec_t irq_out
);
  import nisc_pkg::*;
  nisc_vec_t pls_q;
  always_ff @(posedge clk_in)
  begin
    pls_q <= fire_in;
  end
  // level lines stay up until the bench drops them
  assign irq_out = hold_in | pls_q;
endmodule

// ==== tb/test_nested_interrupt_state_ctrl.sv ====
// Purpose: self-checking bench of the pending/active state block
// Assumes: registers reached over AXI4-Lite, one access at a time
// Notes: no random stimulus
`timescale 1ns/10ps
`include "nisc_params.svh"
module test_nested_interrupt_state_ctrl;
  import nisc_pkg::*;
  logic clk_in, rstn_in, nmi, evirq, ce;
  nisc_vec_t hold, fire, irq;
  nisc_core_req_t core_req;
  nisc_core_rsp_t core_rsp;
  nisc_axi_req_t axi_req;
  nisc_axi_rsp_t axi_rsp;
  int err_count, compares;
  logic [31:0] d;
  logic [1:0] r;
  nisc_src_model i_src (.clk_in(clk_in), .hold_in(hold), .fire_in(fire),
    .irq_out(irq));
  nisc_ctrl i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce),
    .irq_in(irq), .nmi_in(nmi), .core_in(core_req), .core_out(core_rsp),
    .axi_in(axi_req), .axi_out(axi_rsp), .evirq_out(evirq));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic end_of_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    axi_req.awaddr <= a;
    axi_req.wdata <= v;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_in);
      if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
    end
    while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
    end
    while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic core(input logic t, input nisc_id_t id);
    @(posedge clk_in);
    core_req.take <= t;
    core_req.ret <= !t;
    core_req.take_id <= id;
    core_req.ret_id <= id;
    @(posedge clk_in);
    core_req.take <= 1'b0;
    core_req.ret <= 1'b0;
    idle(2);
  endtask
  task automatic pulse5;
    @(posedge clk_in);
    fire[5] <= 1'b1;
    @(posedge clk_in);
    fire[5] <= 1'b0;
    idle(3);
  endtask
  task automatic t_level;
    rdc(`NISC_OFS_ACTIVE, 32'h0);
    hold[3] <= 1'b1;
    idle(3);
    rdc(`NISC_OFS_SETPEND, 32'h8);
    core(1'b1, 5'd3);
    rdc(`NISC_OFS_SETPEND, 32'h0);
    rdc(`NISC_OFS_ACTIVE, 32'h8);
    core(1'b0, 5'd3);
    rdc(`NISC_OFS_SETPEND, 32'h8);
    wr(`NISC_OFS_CLRPEND, 32'h8);
    rdc(`NISC_OFS_SETPEND, 32'h8);
    hold[3] <= 1'b0;
    core(1'b1, 5'd3);
    core(1'b0, 5'd3);
    rdc(`NISC_OFS_SETPEND, 32'h0);
    wr(`NISC_OFS_SETPEND, 32'h8);
    wr(`NISC_OFS_CLRPEND, 32'h8);
    rdc(`NISC_OFS_SETPEND, 32'h0);
  endtask
  task automatic t_pulse;
    wr(`NISC_OFS_PULSE, 32'h20);
    pulse5();
    rdc(`NISC_OFS_SETPEND, 32'h20);
    core(1'b1, 5'd5);
    pulse5();
    rdc(`NISC_OFS_ACTIVE, 32'h20);
    rdc(`NISC_OFS_SETPEND, 32'h20);
    core(1'b0, 5'd5);
    rdc(`NISC_OFS_ACTIVE, 32'h0);
    rdc(`NISC_OFS_SETPEND, 32'h20);
    core(1'b1, 5'd5);
    pulse5();
    wr(`NISC_OFS_CLRPEND, 32'h20);
    rdc(`NISC_OFS_SETPEND, 32'h0);
    rdc(`NISC_OFS_ACTIVE, 32'h20);
    core(1'b0, 5'd5);
    rdc(`NISC_OFS_ACTIVE, 32'h0);
    rdc(`NISC_OFS_SETPEND, 32'h0);
  endtask
  task automatic t_soft;
    wr(`NISC_OFS_SETPEND, 32'h80);
    wr(`NISC_OFS_SOFTWARE_TRIGGER_REG, 32'd9);
    wr(`NISC_OFS_SOFTWARE_TRIGGER_REG, 32'd30);
    rdc(`NISC_OFS_SETPEND, 32'h280);
    wr(`NISC_OFS_PRIO0, 32'h5000_0000);
    wr(`NISC_OFS_PRIO0 + 8'h04, 32'h20);
    wr(`NISC_OFS_ENABLE, 32'h280);
    idle(3);
    chk(core_rsp.irq_id, 32'd9);
    rdc(`NISC_OFS_EVSTAT, 32'h1);
    wr(`NISC_OFS_PRIO0, 32'h2000_0000);
    idle(3);
    chk(core_rsp.irq_id, 32'd7);
    wr(`NISC_OFS_GROUP, 32'd2);
    idle(3);
    chk({core_rsp.irq_group, core_rsp.irq_sub}, 32'h2);
    wr(`NISC_OFS_GROUP, 32'd1);
    idle(3);
    chk({core_rsp.irq_group, core_rsp.irq_sub}, 32'h10);
    wr(`NISC_OFS_CLRPEND, 32'h280);
    wr(`NISC_OFS_ENABLE, 32'h0);
  endtask
  task automatic t_event;
    wr(`NISC_OFS_EVCLR, 32'h3);
    wr(`NISC_OFS_EVEN, 32'h2);
    nmi <= 1'b1;
    idle(3);
    chk(core_rsp.nmi, 32'h1);
    chk(evirq, 32'h1);
    wr(`NISC_OFS_EVEN, 32'h0);
    idle(2);
    chk(evirq, 32'h0);
    wr(`NISC_OFS_EVEN, 32'h2);
    wr(`NISC_OFS_EVCLR, 32'h2);
    idle(2);
    chk(evirq, 32'h0);
    rdc(`NISC_OFS_EVSTAT, 32'h0);
    rd(8'h30);
    chk(r, `NISC_RESP_SLVERR);
  endtask
  // a level request that comes and goes while frozen must leave no trace
  task automatic t_freeze;
    ce <= 1'b0;
    hold[4] <= 1'b1;
    idle(3);
    hold[4] <= 1'b0;
    idle(1);
    ce <= 1'b1;
    rdc(`NISC_OFS_SETPEND, 32'h0);
  endtask
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    err_count = 0;
    compares = 0;
    rstn_in = 1'b0;
    ce = 1'b1;
    nmi = 1'b0;
    hold = '0;
    fire = '0;
    core_req = '0;
    axi_req = '0;
    axi_req.wstrb = 4'hf;
    idle(8);
    rstn_in <= 1'b1;
    t_level();
    t_pulse();
    t_soft();
    t_event();
    t_freeze();
    end_of_test();
  end
endmodule
